// ---- logic/ddrini_ctrl.sv ----
// Host-side controller that initializes a DDR module and keeps it refreshed.
// Assumes the memory clock is clk_i itself and pins are registered outside.
//
// Operation
// - Hold clock-enable low while the clock runs through the power-up wait.
// - After at least 200us stable clock, raise clock-enable and send NOPs.
// - Issue precharge-all, then wait tRP sending only NOPs.
// - Load extended mode: DLL enabled, drive strength chosen, upper bits zero.
// - Wait tMRD with NOPs after every mode-register load.
// - Load base mode register with operating parameters and DLL reset set.
// - Allow 200 cycles between DLL reset load and the first read.
// - After base mode wait, issue second precharge-all and wait tRP.
// - Issue two auto refreshes, each followed by tRFC of NOPs.
// - Optionally reload base mode with DLL reset cleared, then wait tMRD.
// - Keep clock-enable high from each refresh until it completes.
// - On clock frequency change, reset the DLL and wait 200 cycles.
// - Refresh at least every 70.3us; never postpone more than eight.
`timescale 1ns/100ps
module ddrini_ctrl #(
   parameter int PWRUP_CYC  = ddrini_pkg::PWRUP_CYCLES,
   parameter int REFMAX_CYC = ddrini_pkg::REFMAX_CYCLES,
   parameter int DLL_CYC    = ddrini_pkg::DLL_LOCK_CYCLES,
   parameter int TW         = 16
) (
   input  wire logic                          clk_i,
   input  wire logic                          nrst_i,
   input  wire logic [ddrini_pkg::ADDR_W-1:0] mode_i,
   input  wire logic                          reduced_drive_i,
   input  wire logic                          clear_dll_i,
   input  wire logic                          freq_change_i,
   output logic                               cke_o,
   output logic                               cs_n_o,
   output logic                               ras_n_o,
   output logic                               cas_n_o,
   output logic                               we_n_o,
   output logic [ddrini_pkg::BA_W-1:0]        ba_o,
   output logic [ddrini_pkg::ADDR_W-1:0]      addr_o,
   output logic                               init_done_o,
   output logic                               read_ok_o,
   output logic                               refresh_busy_o
);

   // ************************************************************
   // State and counters
   // ************************************************************
   ddrini_pkg::ddrini_state_t state_reg, state_next;
   logic [3:0]                    cmd_reg, cmd_next;
   logic [ddrini_pkg::BA_W-1:0]   ba_reg, ba_next;
   logic [ddrini_pkg::ADDR_W-1:0] addr_reg, addr_next;
   logic                          cke_reg, cke_next;
   logic [TW-1:0]                 dll_cnt_reg;
   logic [TW-1:0]                 ref_cnt_reg;
   logic                          issue;
   logic                          load;
   logic [TW-1:0]                 load_cnt;
   logic                          done;
   logic                          dll_start;
   logic                          ref_due;
   logic                          ref_issue;
   logic                          ref_wait_reg;
   logic                          pwr_loaded_reg;

   // Waits are loaded as count minus one because the issuing cycle already counts.
   function automatic logic [TW-1:0] wcnt(input int cyc);
      wcnt = TW'(cyc - 1);
   endfunction : wcnt

   ddrini_timer #(
      .WIDTH (TW)
   ) u_timer (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .load_i  (load),
      .count_i (load_cnt),
      .done_o  (done)
   );

   // ************************************************************
   // Sequence decode
   // ************************************************************
   assign issue     = done && (cmd_reg == ddrini_pkg::CMD_NOP || cmd_reg == ddrini_pkg::CMD_DESEL);
   assign ref_due   = (ref_cnt_reg >= TW'(REFMAX_CYC - ddrini_pkg::RFC_CYCLES));
   assign ref_issue = issue && (state_reg == ddrini_pkg::DDRINI_READY) && ref_due;
   assign dll_start = issue && (state_reg == ddrini_pkg::DDRINI_MR_DLL);

   always_comb
   begin
      state_next = state_reg;
      cmd_next   = ddrini_pkg::CMD_NOP;
      ba_next    = ba_reg;
      addr_next  = addr_reg;
      cke_next   = cke_reg;
      load       = 1'b0;
      load_cnt   = '0;
      unique case (state_reg)
         ddrini_pkg::DDRINI_POWERUP:
         begin
            cke_next = 1'b0;
            cmd_next = ddrini_pkg::CMD_DESEL;
            if (!pwr_loaded_reg)
            begin
               load     = 1'b1;
               load_cnt = wcnt(PWRUP_CYC);
            end
            else if (done)
            begin
               cke_next   = 1'b1;
               cmd_next   = ddrini_pkg::CMD_NOP;
               load       = 1'b1;
               load_cnt   = wcnt(1);
               state_next = ddrini_pkg::DDRINI_CKE_NOP;
            end
         end
         ddrini_pkg::DDRINI_CKE_NOP:
            if (issue)
            begin
               cmd_next   = ddrini_pkg::CMD_PRE;
               addr_next  = '0;
               addr_next[ddrini_pkg::PRE_ALL_BIT] = 1'b1;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::RP_CYCLES);
               state_next = ddrini_pkg::DDRINI_PRE1;
            end
         ddrini_pkg::DDRINI_PRE1:
            if (issue)
            begin
               cmd_next   = ddrini_pkg::CMD_LMR;
               ba_next    = ddrini_pkg::BA_EMODE;
               addr_next  = '0;
               addr_next[ddrini_pkg::DLL_DISABLE_BIT]    = 1'b0;
               addr_next[ddrini_pkg::DRIVE_STRENGTH_BIT] = reduced_drive_i;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::MRD_CYCLES);
               state_next = ddrini_pkg::DDRINI_EMR;
            end
         ddrini_pkg::DDRINI_EMR, ddrini_pkg::DDRINI_WAIT:
            if (issue)
            begin
               cmd_next   = ddrini_pkg::CMD_LMR;
               ba_next    = ddrini_pkg::BA_MODE;
               addr_next  = mode_i;
               addr_next[ddrini_pkg::DLL_RESET_BIT] = 1'b1;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::MRD_CYCLES);
               state_next = ddrini_pkg::DDRINI_MR_DLL;
            end
         ddrini_pkg::DDRINI_MR_DLL:
            if (issue)
            begin
               cmd_next   = ddrini_pkg::CMD_PRE;
               ba_next    = '0;
               addr_next  = '0;
               addr_next[ddrini_pkg::PRE_ALL_BIT] = 1'b1;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::RP_CYCLES);
               state_next = ddrini_pkg::DDRINI_PRE2;
            end
         ddrini_pkg::DDRINI_PRE2, ddrini_pkg::DDRINI_REF1:
            if (issue)
            begin
               cmd_next   = ddrini_pkg::CMD_REF;
               ba_next    = '0;
               addr_next  = '0;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::RFC_CYCLES);
               state_next = (state_reg == ddrini_pkg::DDRINI_PRE2) ?
                            ddrini_pkg::DDRINI_REF1 : ddrini_pkg::DDRINI_REF2;
            end
         ddrini_pkg::DDRINI_REF2:
            if (issue)
            begin
               if (clear_dll_i)
               begin
                  cmd_next   = ddrini_pkg::CMD_LMR;
                  ba_next    = ddrini_pkg::BA_MODE;
                  addr_next  = mode_i;
                  addr_next[ddrini_pkg::DLL_RESET_BIT] = 1'b0;
                  load       = 1'b1;
                  load_cnt   = wcnt(ddrini_pkg::MRD_CYCLES);
                  state_next = ddrini_pkg::DDRINI_MR_CLR;
               end
               else
               begin
                  state_next = ddrini_pkg::DDRINI_READY;
               end
            end
         ddrini_pkg::DDRINI_MR_CLR:
            if (issue)
            begin
               state_next = ddrini_pkg::DDRINI_READY;
            end
         ddrini_pkg::DDRINI_READY:
            if (ref_issue)
            begin
               cmd_next   = ddrini_pkg::CMD_REF;
               ba_next    = '0;
               addr_next  = '0;
               load       = 1'b1;
               load_cnt   = wcnt(ddrini_pkg::RFC_CYCLES);
            end
            else if (issue && freq_change_i)
            begin
               // A new clock rate invalidates the DLL lock, so the base load is redone.
               load       = 1'b1;
               load_cnt   = wcnt(1);
               state_next = ddrini_pkg::DDRINI_WAIT;
            end
         default:
            state_next = ddrini_pkg::DDRINI_POWERUP;
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= ddrini_pkg::DDRINI_POWERUP;
         cmd_reg   <= ddrini_pkg::CMD_DESEL;
         ba_reg    <= '0;
         addr_reg  <= '0;
         cke_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cmd_reg   <= cmd_next;
         ba_reg    <= ba_next;
         addr_reg  <= addr_next;
         cke_reg   <= cke_next;
      end
   end

   // The power-up wait is loaded in the first cycle after reset, as the timer idles at zero.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         pwr_loaded_reg <= 1'b0;
      else
         pwr_loaded_reg <= 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         dll_cnt_reg <= '0;
      else if (dll_start)
         dll_cnt_reg <= TW'(DLL_CYC);
      else if (dll_cnt_reg != '0)
         dll_cnt_reg <= dll_cnt_reg - 1'b1;
   end

   // Refresh is issued early by tRFC so no more than one is ever owed.
   // The interval runs from every refresh, init ones too, so the first one in ready is not late.
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         ref_cnt_reg <= '0;
      else if (cmd_next == ddrini_pkg::CMD_REF)
         ref_cnt_reg <= '0;
      else if (!ref_due)
         ref_cnt_reg <= ref_cnt_reg + 1'b1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         ref_wait_reg <= 1'b0;
      else if (cmd_reg == ddrini_pkg::CMD_REF)
         ref_wait_reg <= 1'b1;
      else if (done)
         ref_wait_reg <= 1'b0;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign cke_o          = cke_reg;
   assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_reg;
   assign ba_o           = ba_reg;
   assign addr_o         = addr_reg;
   assign init_done_o    = (state_reg == ddrini_pkg::DDRINI_READY);
   assign read_ok_o      = init_done_o && (dll_cnt_reg == '0) && !ref_wait_reg;
   assign refresh_busy_o = ref_wait_reg || (cmd_reg == ddrini_pkg::CMD_REF);

endmodule : ddrini_ctrl

// ---- logic/ddrini_pkg.sv ----
// Package of the DDR module initialization controller: command codes, mode bits, timings.
// Assumes a 100 MHz controller clock; all waits are counted in cycles of that clock.
package ddrini_pkg;

   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int CLK_PERIOD_PS    = 10000;
   localparam int T_PWRUP_US       = 200;
   localparam int T_RP_PS          = 20000;
   localparam int T_MRD_PS         = 15000;
   localparam int T_RFC_PS         = 75000;
   localparam int T_REFMAX_NS      = 70300;
   localparam int T_RAS_MIN_NS     = 40;
   localparam int T_RAS_MAX_NS     = 120000;
   localparam int DLL_LOCK_CYCLES  = 200;
   localparam int MAX_POSTED_REF   = 8;

   function automatic int cyc_up(input int ps);
      cyc_up = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      if (cyc_up < 1)
      begin
         cyc_up = 1;
      end
   endfunction : cyc_up

   function automatic int cyc_down(input int ps);
      cyc_down = ps / CLK_PERIOD_PS;
      if (cyc_down < 1)
      begin
         cyc_down = 1;
      end
   endfunction : cyc_down

   localparam int PWRUP_CYCLES  = cyc_up(T_PWRUP_US * 1000000);
   localparam int RP_CYCLES     = cyc_up(T_RP_PS);
   localparam int MRD_CYCLES    = cyc_up(T_MRD_PS);
   localparam int RFC_CYCLES    = cyc_up(T_RFC_PS);
   localparam int REFMAX_CYCLES = cyc_down(T_REFMAX_NS * 1000);
   localparam int RAS_MIN_CYCLES = cyc_up(T_RAS_MIN_NS * 1000);
   localparam int RAS_MAX_CYCLES = cyc_down(T_RAS_MAX_NS * 1000);

   // ************************************************************
   // Commands as {cs_n, ras_n, cas_n, we_n}
   // ************************************************************
   localparam logic [3:0] CMD_DESEL = 4'h8;
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_LMR   = 4'h0;

   // ************************************************************
   // Address fields
   // ************************************************************
   localparam int ADDR_W            = 13;
   localparam int BA_W              = 2;
   localparam int PRE_ALL_BIT       = 10;
   localparam int DLL_DISABLE_BIT   = 0;
   localparam int DRIVE_STRENGTH_BIT = 1;
   localparam int DLL_RESET_BIT     = 8;
   localparam logic [1:0] BA_MODE   = 2'h0;
   localparam logic [1:0] BA_EMODE  = 2'h1;

   typedef enum logic [3:0] {
      DDRINI_POWERUP  = 4'b0000,
      DDRINI_CKE_NOP  = 4'b0001,
      DDRINI_PRE1     = 4'b0010,
      DDRINI_EMR      = 4'b0011,
      DDRINI_MR_DLL   = 4'b0100,
      DDRINI_PRE2     = 4'b0101,
      DDRINI_REF1     = 4'b0110,
      DDRINI_REF2     = 4'b0111,
      DDRINI_MR_CLR   = 4'b1000,
      DDRINI_WAIT     = 4'b1001,
      DDRINI_READY    = 4'b1010
   } ddrini_state_t;

endpackage : ddrini_pkg

// ---- logic/ddrini_timer.sv ----
// Down-counting wait timer used for every initialization and refresh wait except the DLL lock wait.
// Assumes the loader gives a count of at least one cycle.
`timescale 1ns/100ps
module ddrini_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] count_i,
   output logic                  done_o
);

   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;

   assign cnt_next = load_i ? count_i : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
   // Done ignores the load strobe: the loader decides on done, so that path would close a loop.
   assign done_o   = (cnt_reg == '0);

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end

endmodule : ddrini_timer

// ---- bench/ddrini_ctrl_chk.sv ----
// Checker of the DDR init controller: command order, waits and status flags.
// Assumes it is bound into ddrini_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module ddrini_ctrl_chk #(
   parameter int PWRUP_CYC  = 50,
   parameter int REFMAX_CYC = 200,
   parameter int DLL_CYC    = 200
) (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic [12:0] mode_i,
   input wire logic        reduced_drive_i,
   input wire logic        cke_o,
   input wire logic        cs_n_o,
   input wire logic        ras_n_o,
   input wire logic        cas_n_o,
   input wire logic        we_n_o,
   input wire logic [1:0]  ba_o,
   input wire logic [12:0] addr_o,
   input wire logic        init_done_o,
   input wire logic        read_ok_o
);
   // ************************************************************
   // Helper counters
   // ************************************************************
   // One cycle of slack on both minimums: the pins lag the internal decision.
   localparam int   PWR_MIN = PWRUP_CYC - 1;
   localparam int   DLL_MIN = DLL_CYC - 1;
   wire logic [3:0] cmd     = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
   wire logic       is_lmr  = (cmd == ddrini_pkg::CMD_LMR);
   wire logic       dll_rst = is_lmr && (ba_o == ddrini_pkg::BA_MODE) && addr_o[8];
   int              low_cnt;
   int              dll_cnt;
   int              ref_cnt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge clk_i)
   begin
      low_cnt <= (!nrst_i) ? 0 : low_cnt + int'(!cke_o);
      dll_cnt <= (!nrst_i || dll_rst) ? 0 : dll_cnt + 1;
      ref_cnt <= (!nrst_i || cmd == ddrini_pkg::CMD_REF) ? 0 : ref_cnt + 1;
   end
   // ************************************************************
   // Assertions
   // ************************************************************
   AST_RST_IDLE: assert property ($rose(nrst_i) |-> !cke_o && cs_n_o && !init_done_o)
      else $error("outputs not idle after reset");
   AST_PWRUP: assert property ($rose(cke_o) |-> low_cnt >= PWR_MIN)
      else $error("clock enable raised too early");
   AST_CKE_HOLD: assert property (cke_o |=> cke_o)
      else $error("clock enable dropped");
   AST_PRE_FIRST: assert property ($rose(cke_o) |-> cmd == ddrini_pkg::CMD_NOP ##1
      (cmd == ddrini_pkg::CMD_PRE && addr_o[10])) else $error("no precharge-all after rise");
   AST_PRE_WAIT: assert property (cmd == ddrini_pkg::CMD_PRE |=> cmd == ddrini_pkg::CMD_NOP)
      else $error("precharge wait broken");
   AST_LMR_WAIT: assert property (is_lmr |=> cmd == ddrini_pkg::CMD_NOP)
      else $error("mode load wait broken");
   AST_EMR_BITS: assert property (is_lmr && ba_o == ddrini_pkg::BA_EMODE |->
      addr_o == {11'h000, reduced_drive_i, 1'b0}) else $error("extended mode value wrong");
   AST_MR_DLL: assert property (is_lmr && ba_o == ddrini_pkg::BA_EMODE |-> ##2
      (dll_rst && addr_o == (mode_i | 13'h0100))) else $error("base mode load wrong");
   AST_REF_CKE: assert property (cmd == ddrini_pkg::CMD_REF |-> cke_o ##1
      (cke_o && cmd == ddrini_pkg::CMD_NOP)[*7]) else $error("refresh wait broken");
   AST_READ_GAP: assert property (read_ok_o |-> init_done_o && dll_cnt >= DLL_MIN)
      else $error("read allowed too soon");
   AST_REF_GAP: assert property (init_done_o |-> ref_cnt <= REFMAX_CYC)
      else $error("refresh interval too long");
   COV_REF: cover property (cmd == ddrini_pkg::CMD_REF);
   COV_READY: cover property ($rose(read_ok_o));
   COV_RELOAD: cover property ($fell(init_done_o));
endmodule : ddrini_ctrl_chk
bind ddrini_ctrl ddrini_ctrl_chk #(
   .PWRUP_CYC(PWRUP_CYC), .REFMAX_CYC(REFMAX_CYC), .DLL_CYC(DLL_CYC)
) chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .reduced_drive_i(reduced_drive_i),
   .cke_o(cke_o), .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
   .ba_o(ba_o), .addr_o(addr_o), .init_done_o(init_done_o), .read_ok_o(read_ok_o)
);

// ---- bench/ddrini_mem_model.sv ----
// Behavioural memory module: watches the command pins and counts protocol faults.
// Assumes the bench ties its reset to the controller's reset as a power cycle.
`timescale 1ns/100ps
module ddrini_mem_model #(
   parameter int PWRUP_CYC = 50
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [1:0]  ba_i,
   input  wire logic [12:0] addr_i,
   output logic             ready_o,
   output logic [7:0]       viol_o
);
   // ************************************************************
   // Sequence tracking
   // ************************************************************
   localparam int         CK = ddrini_pkg::CLK_PERIOD_PS;
   localparam int         RP = (ddrini_pkg::T_RP_PS + CK - 1) / CK;
   localparam int         MRD = (ddrini_pkg::T_MRD_PS + CK - 1) / CK;
   localparam int         RFC = (ddrini_pkg::T_RFC_PS + CK - 1) / CK;
   localparam logic [3:0] SEQ [6] = '{4'h2, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1};
   wire logic [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   wire logic       act = !cs_n_i && (cmd != ddrini_pkg::CMD_NOP);
   int              wait_cnt;
   int              low_cnt;
   int              step;
   logic            refw;
   // No rows are opened here, so the row-active limits never come into play.
   assign ready_o = (step >= 6);
   wire logic seq_bad = act && (step < 6) && ((cmd !== SEQ[step])
      || (step == 1 && (ba_i != 2'h1 || addr_i[0] || addr_i[12:2] != 11'h000))
      || (step == 2 && (ba_i != 2'h0 || !addr_i[8]))
      || (step == 0 && low_cnt < PWRUP_CYC - 1));
   wire logic bad = seq_bad || (act && (wait_cnt > 1 || !cke_i))
      || (refw && wait_cnt > 0 && !cke_i);
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         wait_cnt <= 0;
         low_cnt <= 0;
         step <= 0;
         refw <= 1'b0;
         viol_o <= 8'h00;
      end
      else
      begin
         low_cnt <= low_cnt + int'(!cke_i);
         viol_o <= viol_o + {7'h00, bad};
         wait_cnt <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
         if (act)
         begin
            refw <= (cmd == ddrini_pkg::CMD_REF);
            wait_cnt <= (cmd == ddrini_pkg::CMD_PRE) ? RP : (cmd == ddrini_pkg::CMD_LMR) ? MRD : RFC;
            step <= (step < 6) ? step + 1 : step;
         end
      end
   end
endmodule : ddrini_mem_model

// ---- bench/tb_top.sv ----
// Self-checking bench of the DDR init controller against a module model.
// Assumes package, controller, checker and model are compiled before it.
`timescale 1ns/100ps
module tb_top;
   localparam int          PWR  = 50;
   localparam int          REFM = 200;
   localparam int          DLLC = 200;
   localparam logic [18:0] PMSK = 19'h7_8400;
   logic                   clk_i = 1'b0;
   logic                   nrst_i = 1'b0;
   logic [12:0]            mode_i = 13'h0032;
   logic                   red_i = 1'b0;
   logic                   clr_i = 1'b0;
   logic                   frq_i = 1'b0;
   logic                   cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, done_o, rok_o, busy_o, ready;
   logic [1:0]             ba_o;
   logic [12:0]            addr_o;
   logic [7:0]             viol;
   logic [18:0]            seen_q[$];
   int                     err_count = 0;
   int                     checks_done = 0;
   int                     cyc = 0;
   int                     since_dll = 0;
   wire logic [3:0]        cmd = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
   always #5 clk_i = ~clk_i;
   ddrini_ctrl #(.PWRUP_CYC(PWR), .REFMAX_CYC(REFM), .DLL_CYC(DLLC)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .mode_i(mode_i), .reduced_drive_i(red_i),
      .clear_dll_i(clr_i), .freq_change_i(frq_i), .cke_o(cke_o), .cs_n_o(cs_n_o),
      .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .ba_o(ba_o), .addr_o(addr_o),
      .init_done_o(done_o), .read_ok_o(rok_o), .refresh_busy_o(busy_o));
   ddrini_mem_model #(.PWRUP_CYC(PWR)) mem (
      .clk_i(clk_i), .nrst_i(nrst_i), .cke_i(cke_o), .cs_n_i(cs_n_o), .ras_n_i(ras_n_o),
      .cas_n_i(cas_n_o), .we_n_i(we_n_o), .ba_i(ba_o), .addr_i(addr_o), .ready_o(ready),
      .viol_o(viol));
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic check(input string name, input logic [18:0] seen, input logic [18:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   // The cycle ceiling cuts a hang; the whole run needs under two thousand cycles.
   always @(posedge clk_i)
   begin
      cyc++;
      since_dll++;
      if (!cs_n_o && cmd != ddrini_pkg::CMD_NOP)
         seen_q.push_back({cmd, ba_o, addr_o});
      if (cmd == ddrini_pkg::CMD_LMR && ba_o == ddrini_pkg::BA_MODE && addr_o[8])
         since_dll = 0;
      if (cyc == 5000)
      begin
         err_count++;
         final_report();
      end
   end
   task automatic t_init(input logic red, input logic clr, input logic [12:0] mode);
      red_i = red;
      clr_i = clr;
      mode_i = mode;
      nrst_i = 1'b0;
      tick(5);
      nrst_i = 1'b1;
      seen_q.delete();
      for (int i = 0; i < PWR + 200 && done_o !== 1'b1; i++)
         tick(1);
      check("cmd_count", 19'(seen_q.size()), 19'(6 + clr));
      check("pre_all_1", seen_q[0] & PMSK, {ddrini_pkg::CMD_PRE, 15'h0400});
      check("ext_load", seen_q[1], {4'h0, ddrini_pkg::BA_EMODE, 11'h000, red, 1'b0});
      check("base_load", seen_q[2], {4'h0, ddrini_pkg::BA_MODE, mode | 13'h0100});
      check("pre_all_2", seen_q[3] & PMSK, {ddrini_pkg::CMD_PRE, 15'h0400});
      check("refresh_1", seen_q[4] & PMSK, {ddrini_pkg::CMD_REF, 15'h0000});
      check("refresh_2", seen_q[5] & PMSK, {ddrini_pkg::CMD_REF, 15'h0000});
      if (clr)
         check("clear_load", seen_q[6], {4'h0, ddrini_pkg::BA_MODE, mode & 13'h1eff});
      check("model_faults", {11'h000, viol}, 19'h0_0000);
   endtask : t_init
   task automatic t_read;
      for (int i = 0; i < DLLC + 50 && rok_o !== 1'b1; i++)
         tick(1);
      check("read_ok", {17'h0_0000, rok_o, ready}, 19'h0_0003);
      check("dll_gap", 19'(since_dll >= DLLC - 1), 19'h0_0001);
   endtask : t_read
   task automatic t_refresh;
      int t1;
      t1 = cyc;
      for (int n = 0; n < 2; n++)
      begin
         for (int i = 0; i < REFM + 20 && cmd !== ddrini_pkg::CMD_REF; i++)
            tick(1);
         check("ref_seen", {15'h0000, cmd}, {15'h0000, ddrini_pkg::CMD_REF});
         if (n == 1)
            check("ref_gap", 19'(cyc - t1 <= REFM), 19'h0_0001);
         t1 = cyc;
         tick(1);
         check("ref_busy", {16'h0000, busy_o, rok_o, cke_o}, 19'h0_0005);
      end
   endtask : t_refresh
   task automatic t_freq;
      int t0;
      t0 = cyc;
      frq_i = 1'b1;
      for (int i = 0; i < REFM && done_o !== 1'b0; i++)
         tick(1);
      frq_i = 1'b0;
      check("reload_busy", {17'h0_0000, done_o, rok_o}, 19'h0_0000);
      for (int i = 0; i < DLLC + 50 && rok_o !== 1'b1; i++)
         tick(1);
      check("reload_dll", 19'(since_dll < cyc - t0), 19'h0_0001);
      check("reload_gap", 19'(since_dll >= DLLC - 1 && rok_o === 1'b1), 19'h0_0001);
   endtask : t_freq
   initial
   begin
      t_init(1'b0, 1'b0, 13'h0032);
      t_read();
      t_init(1'b1, 1'b1, 13'h0163);
      t_read();
      t_refresh();
      t_freq();
      check("model_end", {11'h000, viol}, 19'h0_0000);
      final_report();
   end
endmodule : tb_top
